// ==== hw/axr_pkg.sv ====
// constants for the auxiliary pin, measurement select and alert enable bank
// assumes byte-wide register access from a two-wire bus front end
`default_nettype none
package axr_pkg;
  localparam int AXR_DATA_W = 8;
  localparam int AXR_ADDR_W = 8;
  localparam int AXR_NREG = 7;
  localparam int AXR_NAUX = 4;
  localparam logic [7:0] AXR_OFF_AUX_CFG = 8'h12;
  localparam logic [7:0] AXR_OFF_SEL_SINGLE = 8'h13;
  localparam logic [7:0] AXR_OFF_SEL_DIFF = 8'h14;
  localparam logic [7:0] AXR_OFF_FAULT_EN = 8'h15;
  localparam logic [7:0] AXR_OFF_MEAS_MAIN = 8'h16;
  localparam logic [7:0] AXR_OFF_MEAS_ANALOG = 8'h17;
  localparam logic [7:0] AXR_OFF_MEAS_AUX = 8'h18;
  localparam logic [7:0] AXR_RST_AUX_CFG = 8'hf0;
  localparam logic [7:0] AXR_RST_SEL_SINGLE = 8'hff;
  localparam logic [7:0] AXR_RST_SEL_DIFF = 8'h0f;
  localparam logic [7:0] AXR_RST_FAULT_EN = 8'h00;
  localparam logic [7:0] AXR_RST_MEAS = 8'h00;
  localparam int AXR_DIR_LSB = 4;
  localparam int AXR_LVL_LSB = 0;
  localparam int AXR_BIT_EN_CHANGE = 7;
  localparam int AXR_BIT_NVM_WRITE = 6;
  localparam int AXR_NMEAS_MAIN = 6;
  localparam logic [7:0] AXR_READ_UNMAPPED = 8'h00;
endpackage
`default_nettype wire

// ==== hw/axr_regs.sv ====
// configuration bank: auxiliary pins, measurement select, alert enables
// assumes a byte-wide register port decoded by the two-wire bus front end,
// and fault / threshold event pulses from the monitor on core_clk
//
// Operation
// - direction bits 7..4 of aux config; one is input, reset one
// - level bits 3..0 of aux config drive pins set as outputs, reset zero
// - single select bits pick aux pins and analog inputs, reset all ones
// - diff select bits 7..4 add differential pairs, reset zero
// - diff select bits 3..0 pick sense, drain and drain-sense, reset one
// - fault alert enable per fault type, bits 7..0, reset zero
// - main alert bit 7 enables alert on enable pin change
// - main alert bit 6 enables alert on nonvolatile memory write
// - main alert bits 5..0 enable sense, supply, power high/low alerts
// - analog alert pairs, input one at bits 7:6, reset zero
// - aux pin alert pairs, pin one at bits 7:6, reset zero
// - any enabled alert latches a status bit, cleared only by alert_status_clear or reset
`timescale 1ns/100ps
`default_nettype none
module axr_regs #(
  parameter int NAUX = axr_pkg::AXR_NAUX
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [axr_pkg::AXR_ADDR_W-1:0] reg_addr,
  input wire logic [axr_pkg::AXR_DATA_W-1:0] reg_wdata,
  output logic [axr_pkg::AXR_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic alert_status_clear,
  input wire logic [NAUX-1:0] aux_pin_in,
  output logic [NAUX-1:0] aux_pin_out,
  output logic [NAUX-1:0] aux_pin_oe,
  output logic [NAUX-1:0] aux_pin_in_sync,
  output logic [7:0] measure_sel_single,
  output logic [7:0] measure_sel_diff,
  input wire logic [7:0] fault_event,
  input wire logic enable_pin,
  input wire logic nvm_write_event,
  input wire logic [axr_pkg::AXR_NMEAS_MAIN-1:0] main_limit_event,
  input wire logic [7:0] analog_limit_event,
  input wire logic [7:0] aux_limit_event,
  output logic alert_generated,
  output logic alert_pulse
);
  // elaboration check: the logic serves exactly four pins
  if (NAUX != axr_pkg::AXR_NAUX)
  begin : g_naux_check
    $error("axr_regs: NAUX must equal the four register bits");
  end

  logic [7:0] aux_pin_config;
  logic [7:0] measure_select_single;
  logic [7:0] measure_select_diff;
  logic [7:0] fault_alert_enable;
  logic [7:0] measure_alert_enable_main;
  logic [7:0] measure_alert_enable_analog_in;
  logic [7:0] measure_alert_enable_aux_pin;
  logic [NAUX-1:0] aux_sync;
  logic en_sync;
  logic en_prev;
  logic en_changed;
  logic next_alert;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  axr_sync #(.WIDTH(NAUX + 1)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({enable_pin, aux_pin_in}),
    .sync_out({en_sync, aux_sync})
  );

  // register writes, each byte kept whole
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      aux_pin_config <= axr_pkg::AXR_RST_AUX_CFG;
      measure_select_single <= axr_pkg::AXR_RST_SEL_SINGLE;
      measure_select_diff <= axr_pkg::AXR_RST_SEL_DIFF;
      fault_alert_enable <= axr_pkg::AXR_RST_FAULT_EN;
      measure_alert_enable_main <= axr_pkg::AXR_RST_MEAS;
      measure_alert_enable_analog_in <= axr_pkg::AXR_RST_MEAS;
      measure_alert_enable_aux_pin <= axr_pkg::AXR_RST_MEAS;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, axr_pkg::AXR_OFF_AUX_CFG))
        aux_pin_config <= reg_wdata;
      if (hit(reg_addr, axr_pkg::AXR_OFF_SEL_SINGLE))
        measure_select_single <= reg_wdata;
      if (hit(reg_addr, axr_pkg::AXR_OFF_SEL_DIFF))
        measure_select_diff <= reg_wdata;
      if (hit(reg_addr, axr_pkg::AXR_OFF_FAULT_EN))
        fault_alert_enable <= reg_wdata;
      if (hit(reg_addr, axr_pkg::AXR_OFF_MEAS_MAIN))
        measure_alert_enable_main <= reg_wdata;
      if (hit(reg_addr, axr_pkg::AXR_OFF_MEAS_ANALOG))
        measure_alert_enable_analog_in <= reg_wdata;
      if (hit(reg_addr, axr_pkg::AXR_OFF_MEAS_AUX))
        measure_alert_enable_aux_pin <= reg_wdata;
    end
  end

  // read mux
  always_comb
  begin
    next_rdata = axr_pkg::AXR_READ_UNMAPPED;
    case (reg_addr)
      axr_pkg::AXR_OFF_AUX_CFG: next_rdata = aux_pin_config;
      axr_pkg::AXR_OFF_SEL_SINGLE: next_rdata = measure_select_single;
      axr_pkg::AXR_OFF_SEL_DIFF: next_rdata = measure_select_diff;
      axr_pkg::AXR_OFF_FAULT_EN: next_rdata = fault_alert_enable;
      axr_pkg::AXR_OFF_MEAS_MAIN: next_rdata = measure_alert_enable_main;
      axr_pkg::AXR_OFF_MEAS_ANALOG:
        next_rdata = measure_alert_enable_analog_in;
      axr_pkg::AXR_OFF_MEAS_AUX: next_rdata = measure_alert_enable_aux_pin;
      default: next_rdata = axr_pkg::AXR_READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // aux pin drivers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < NAUX; gi++)
    begin : g_aux
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          aux_pin_oe[gi] <= 1'b0;
          aux_pin_out[gi] <= 1'b0;
        end
        else
        begin
          // one in direction bit means input, so no drive
          aux_pin_oe[gi] <=
            ~aux_pin_config[axr_pkg::AXR_DIR_LSB + gi];
          // level reaches the pin only while it is an output
          aux_pin_out[gi] <= aux_pin_config[axr_pkg::AXR_LVL_LSB + gi]
            & ~aux_pin_config[axr_pkg::AXR_DIR_LSB + gi];
        end
      end
    end
  endgenerate

  // selections and synchronised inputs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      measure_sel_single <= axr_pkg::AXR_RST_SEL_SINGLE;
      measure_sel_diff <= axr_pkg::AXR_RST_SEL_DIFF;
      aux_pin_in_sync <= '0;
    end
    else
    begin
      measure_sel_single <= measure_select_single;
      measure_sel_diff <= measure_select_diff;
      aux_pin_in_sync <= aux_sync;
    end
  end

  // enable pin change detect on synchronised level
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      en_prev <= 1'b0;
    else
      en_prev <= en_sync;
  end

  assign en_changed = en_sync ^ en_prev;

  // gate every source by its enable bit
  always_comb
  begin
    next_alert = |(fault_event & fault_alert_enable)
      | (en_changed
         & measure_alert_enable_main[axr_pkg::AXR_BIT_EN_CHANGE])
      | (nvm_write_event
         & measure_alert_enable_main[axr_pkg::AXR_BIT_NVM_WRITE])
      | |(main_limit_event
          & measure_alert_enable_main[axr_pkg::AXR_NMEAS_MAIN-1:0])
      | |(analog_limit_event & measure_alert_enable_analog_in)
      | |(aux_limit_event & measure_alert_enable_aux_pin);
  end

  // sticky status, set wins over clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      alert_generated <= 1'b0;
      alert_pulse <= 1'b0;
    end
    else
    begin
      alert_pulse <= next_alert;
      if (next_alert)
        alert_generated <= 1'b1;
      else if (alert_status_clear)
        alert_generated <= 1'b0;
    end
  end
endmodule // axr_regs
`default_nettype wire

// ==== hw/axr_sync.sv ====
// two-flop synchroniser for a bus of pin levels
// assumes inputs come from outside the core_clk domain
`timescale 1ns/100ps
`default_nettype none
module axr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // axr_sync
`default_nettype wire

// ==== tb/axr_host.sv ====
// management host model on the byte register port
// assumes core_clk, each strobe high for one cycle
`timescale 1ns/100ps
`default_nettype none
module axr_host (
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic alert_status_clear
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata, alert_status_clear} = '0;
  task automatic put(input logic w, r, c, input logic [7:0] a, d);
    @(posedge core_clk);
    {reg_wr, reg_rd, alert_status_clear} <= {w, r, c};
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    {reg_wr, reg_rd, alert_status_clear} <= 3'b000;
  endtask
endmodule // axr_host
`default_nettype wire

// ==== tb/axr_regs_chk.sv ====
// port checker for the config bank
// assumes one core_clk domain, bound to axr_regs
`timescale 1ns/100ps
`default_nettype none
module axr_regs_chk #(
  parameter int NAUX = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic alert_status_clear,
  input wire logic [NAUX-1:0] aux_pin_out,
  input wire logic [NAUX-1:0] aux_pin_oe,
  input wire logic [7:0] measure_sel_single,
  input wire logic [7:0] measure_sel_diff,
  input wire logic alert_generated,
  input wire logic alert_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_rvn; !reg_rd |=> !reg_rvalid; endproperty
  a_rvn: assert property (p_rvn) else $error("stray rvalid");
  property p_cfg;
    reg_wr && reg_addr == 8'h12 |-> ##2
      aux_pin_oe == ~$past(reg_wdata[7:4], 2)
      && aux_pin_out == ($past(reg_wdata[3:0], 2)
        & ~$past(reg_wdata[7:4], 2));
  endproperty
  a_cfg: assert property (p_cfg) else $error("pin cfg");
  property p_single;
    reg_wr && reg_addr == 8'h13
      |-> ##2 measure_sel_single == $past(reg_wdata, 2);
  endproperty
  a_single: assert property (p_single) else $error("sel single");
  property p_diff;
    reg_wr && reg_addr == 8'h14
      |-> ##2 measure_sel_diff == $past(reg_wdata, 2);
  endproperty
  a_diff: assert property (p_diff) else $error("sel diff");
  property p_rst;
    $fell(rst) |-> measure_sel_single == 8'hff
      && measure_sel_diff == 8'h0f && aux_pin_oe == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset val");
  property p_unmap;
    reg_rd && (reg_addr < 8'h12 || reg_addr > 8'h18) |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_sticky;
    alert_generated && !alert_status_clear |=> alert_generated;
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");
  property p_gen; alert_pulse |-> alert_generated; endproperty
  a_gen: assert property (p_gen) else $error("status unset");
  property p_mask; (aux_pin_out & ~aux_pin_oe) == '0; endproperty
  a_mask: assert property (p_mask) else $error("input drives");
  c_alert: cover property (alert_pulse);
  c_clear: cover property (alert_generated ##1 !alert_generated);
  c_read: cover property (reg_rd ##1 reg_rvalid);
endmodule // axr_regs_chk
bind axr_regs axr_regs_chk #(.NAUX(NAUX)) u_chk (.core_clk(core_clk),
  .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .alert_status_clear(alert_status_clear), .aux_pin_out(aux_pin_out),
  .aux_pin_oe(aux_pin_oe), .measure_sel_single(measure_sel_single),
  .measure_sel_diff(measure_sel_diff), .alert_generated(alert_generated),
  .alert_pulse(alert_pulse));
`default_nettype wire

// ==== tb/tb_axr_regs.sv ====
// self-checking bench for the config bank
// assumes axr_host model and bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_axr_regs;
  logic core_clk = 0, rst = 1, enable_pin = 0;
  logic reg_wr, reg_rd, clr, reg_rvalid, alert_generated, alert_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sel_s, sel_d, d;
  logic [3:0] pin_in = 0, pin_out, pin_oe, pin_sync;
  logic [31:0] ev = 0;
  logic [7:0] exp_q[$];
  int n_errors = 0, checked = 0, npulse = 0;
  initial forever #4 core_clk = ~core_clk;
  axr_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .alert_status_clear(clr));
  axr_regs dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .alert_status_clear(clr), .aux_pin_in(pin_in), .aux_pin_out(pin_out),
    .aux_pin_oe(pin_oe), .aux_pin_in_sync(pin_sync),
    .measure_sel_single(sel_s), .measure_sel_diff(sel_d),
    .fault_event(ev[7:0]), .enable_pin(enable_pin),
    .nvm_write_event(ev[30]), .main_limit_event(ev[13:8]),
    .analog_limit_event(ev[21:14]), .aux_limit_event(ev[29:22]),
    .alert_generated(alert_generated), .alert_pulse(alert_pulse));
  task automatic cmp(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, v);
    exp_q.push_back(v);
    host.put(0, 1, 0, a, 8'h00);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
    if (ev[31])
      enable_pin <= ~enable_pin;
  always @(negedge core_clk)
  begin
    if (alert_pulse === 1'b1)
      npulse++;
    if (reg_rvalid === 1'b1)
      cmp(reg_rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  end
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    give_verdict;
  end
  initial
  begin
    int a, b;
    void'($urandom(32'h86da));
    repeat (12) @(posedge core_clk);
    rst <= 0;
    for (int i = 0; i < 7; i++)
      rd(8'(8'h12 + i), i == 0 ? 8'hf0 : i == 1 ? 8'hff :
        i == 2 ? 8'h0f : 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      d = 8'($urandom);
      host.put(1, 0, 0, 8'(8'h12 + i), d);
      rd(8'(8'h12 + i), d);
      if (i == 0)
        cmp({pin_oe, pin_out}, {~d[7:4], d[3:0] & ~d[7:4]});
      if (i == 1)
        cmp(sel_s, d);
      if (i == 2)
        cmp(sel_d, d);
    end
    host.put(1, 0, 0, 8'h11, 8'hff);
    rd(8'h11, 8'h00);
    rd(8'h19, 8'h00);
    pin_in <= 4'($urandom % 15) + 4'h1;
    repeat (5) @(negedge core_clk);
    cmp({4'h0, pin_sync}, {4'h0, pin_in});
    for (int i = 0; i < 32; i++)
    begin
      a = i < 8 ? 'h15 : (i < 14 || i > 29) ? 'h16 : i < 22 ? 'h17 : 'h18;
      b = i < 8 ? i : i < 14 ? i - 8 : i < 22 ? i - 14 : i < 30 ? i - 22
        : i - 24;
      for (int en = 0; en < 2; en++)
      begin
        host.put(1, 0, 0, 8'(a), 8'(en << b));
        host.put(0, 0, 1, 8'h00, 8'h00);
        npulse = 0;
        ev <= 32'(1) << i;
        @(posedge core_clk);
        ev <= 0;
        repeat (6) @(posedge core_clk);
        cmp(8'(npulse), 8'(en));
        cmp({7'h0, alert_generated}, 8'(en));
      end
    end
    host.put(0, 0, 1, 8'h00, 8'h00);
    @(negedge core_clk);
    cmp({7'h0, alert_generated}, 8'h00);
    give_verdict;
  end
endmodule // tb_axr_regs
`default_nettype wire
